/* File: core/i2sp_defines.svh */
// Register offsets, field positions, reset values and timing figures of the two-wire status and data port.
// Assumes a 10 MHz pclk; included by bare name from the port and the bench.
`ifndef I2SP_DEFINES_SVH
`define I2SP_DEFINES_SVH

// Byte addresses of the registers on the APB.
`define I2SP_OFS_OWN_ADDR 8'h00
`define I2SP_OFS_CONTROL  8'h04
`define I2SP_OFS_STATUS   8'h08
`define I2SP_OFS_DATA     8'h0C
`define I2SP_OFS_CONTROL2 8'h10

// Control register fields.
`define I2SP_CTL_EN   7
`define I2SP_CTL_IE   6
`define I2SP_CTL_MS   5
`define I2SP_CTL_TX   4
`define I2SP_CTL_TXAK 3
`define I2SP_CTL_RSTA 2
`define I2SP_CTL_WMASK 8'hF9
`define I2SP_CTL_RST   8'h00

// Second control register fields.
`define I2SP_CT2_GENERAL_CALL_ACCEPT  7
`define I2SP_CT2_WMASK 8'h80

// Status register fields and reset value.
`define I2SP_ST_TCF  7
`define I2SP_ST_ADDRESSED_AS_SLAVE_FLAG 6
`define I2SP_ST_BB   5
`define I2SP_ST_AL   4
`define I2SP_ST_SRW  2
`define I2SP_ST_IIF  1
`define I2SP_ST_RECEIVED_ACK_FLAG 0
`define I2SP_ST_TCF_RST 1'b1

// Own address reset and the general call address.
`define I2SP_OWN_RST 7'h00
`define I2SP_GENERAL_CALL 7'h00

// Bit counter marks: eight data bits, then the acknowledge clock.
`define I2SP_BIT_ACK  4'h8
`define I2SP_BIT_DONE 4'h9
`define I2SP_BIT_LAST 4'h7

// Timing: pclk period and the serial clock half-period timer load, both in ns; each generated half lasts one pclk longer.
`define I2SP_PCLK_NS     100
`define I2SP_SCL_HALF_NS 400

`endif

/* File: core/i2sp_line_if.sv */
// Raw and synchronised levels of the two bus lines.
// Assumes the raw levels come straight from the pins, outside the pclk domain.
interface i2sp_line_if;
	logic scl_raw;
	logic sda_raw;
	logic scl_sync;
	logic sda_sync;

	modport sync_mp (input scl_raw, input sda_raw, output scl_sync, output sda_sync);
	modport core_mp (output scl_raw, output sda_raw, input scl_sync, input sda_sync);
endinterface

/* File: core/i2sp_pkg.sv */
// Types shared by the two-wire status and data port.
// Assumes nothing beyond the defines header.
package i2sp_pkg;

	// Master sequencer states, Gray coded along idle, start, hold, clocking.
	typedef enum logic [2:0] {
		I2SP_M_IDLE  = 3'h0,
		I2SP_M_START = 3'h1,
		I2SP_M_HOLD  = 3'h3,
		I2SP_M_CLK   = 3'h2,
		I2SP_M_RS    = 3'h6,
		I2SP_M_STOP1 = 3'h7,
		I2SP_M_STOP2 = 3'h5
	} i2sp_mstate_type;

endpackage

/* File: core/i2sp_port.sv */
// Status flags, data port and byte engine of a multi-master two-wire bus interface, reached over APB.
// Assumes open-drain SCL/SDA pins with external pull-ups, and pclk at 10 MHz.
//
// Added by the designer: register access over APB and the register addresses.
`include "i2sp_defines.svh"

// Functional notes
// - Transfer complete clears in transfer, sets ninth fall.
// - Own address or enabled general call sets addressed.
// - Any control register write clears addressed flag.
// - START sets bus busy; STOP clears it.
// - Four arbitration loss cases set lost flag.
// - Lost flag clears only by writing one.
// - Slave direction holds calling address R/W bit.
// - Lost, complete or addressed sets interrupt flag.
// - Interrupt request is flag and enable together.
// - Interrupt flag clears only by writing one.
// - Received acknowledge captures SDA at ninth clock.
// - Reserved status bit always reads zero.
// - Master transmit write sends byte, MSB first.
// - Master receive read starts next byte.
// - Addressed slave: same write and read launches.
// - Access starts transfer only in matching direction.
// - Data read returns last received byte.
// - Master select rise starts, fall stops bus.
module i2sp_port #(
	parameter int HALF_CYC = `I2SP_SCL_HALF_NS / `I2SP_PCLK_NS
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe
);

	i2sp_line_if line ();

	logic [7:0]  ctrl_ff;
	logic [7:0]  nxt_ctrl;
	logic        general_call_accept_ff;
	logic [6:0]  own_ff;
	logic        scl_q_ff;
	logic        sda_q_ff;
	logic [3:0]  bit_ff;
	logic [7:0]  sh_ff;
	logic [7:0]  rx_data_ff;
	logic        xfer_ff;
	logic        tx_byte_ff;
	logic        addr_ph_ff;
	logic        match_ff;
	logic        data_low_ff;
	logic        slv_on_ff;
	logic        slv_hold_ff;
	logic        srw_ff;
	logic        received_ack_flag_ff;
	logic        tcf_ff;
	logic        addressed_as_slave_flag_ff;
	logic        bb_ff;
	logic        al_ff;
	logic        iif_ff;
	logic        scl_low_ff;
	logic        cond_low_ff;
	logic [7:0]  timer_ff;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	i2sp_pkg::i2sp_mstate_type mstate_ff;
	logic [7:0]  status_w;
	logic        scl_s;
	logic        sda_s;
	logic        en;
	logic        is_ms;
	logic        wr;
	logic        rd;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        data_wr;
	logic        data_rd;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        ms_rise;
	logic        ms_fall;
	logic        rsta_req;
	logic        al_ev;
	logic        al_lose;
	logic        ready_w;
	logic        tx_go;
	logic        rx_go;
	logic        go;
	logic        done_w;
	logic        tcf_set;
	logic        addressed_as_slave_flag_set;
	logic        t_zero;
	logic        mapped;
	logic [6:0]  addr_in;

	// Pins pass the synchroniser before anything looks at them.
	assign line.scl_raw = scl_in;
	assign line.sda_raw = sda_in;
	assign scl_s        = line.scl_sync;
	assign sda_s        = line.sda_sync;

	i2sp_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.line    (line)
	);

	// APB decode; the slave never inserts wait states.
	assign wr       = psel & penable & pwrite;
	assign rd       = psel & penable & ~pwrite;
	assign wr_ctrl  = wr & (paddr == `I2SP_OFS_CONTROL);
	assign wr_stat  = wr & (paddr == `I2SP_OFS_STATUS);
	assign data_wr  = wr & (paddr == `I2SP_OFS_DATA);
	assign data_rd  = rd & (paddr == `I2SP_OFS_DATA);
	assign mapped   = (paddr == `I2SP_OFS_OWN_ADDR) | (paddr == `I2SP_OFS_CONTROL) | (paddr == `I2SP_OFS_STATUS) |
	                  (paddr == `I2SP_OFS_DATA) | (paddr == `I2SP_OFS_CONTROL2);
	assign pready   = 1'b1;
	assign prdata   = prdata_ff;
	assign pslverr  = pslverr_ff & psel & penable;

	// Line events, seen on the synchronised levels against their previous values.
	assign scl_rise  = scl_s & ~scl_q_ff;
	assign scl_fall  = ~scl_s & scl_q_ff;
	assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	assign stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

	assign en       = ctrl_ff[`I2SP_CTL_EN];
	assign is_ms    = ctrl_ff[`I2SP_CTL_MS];
	assign ms_rise  = wr_ctrl & pwdata[`I2SP_CTL_MS] & ~is_ms;
	assign ms_fall  = wr_ctrl & ~pwdata[`I2SP_CTL_MS] & is_ms;
	assign rsta_req = wr_ctrl & pwdata[`I2SP_CTL_RSTA];

	// Arbitration loss: master drove high but saw low, busy-bus start, slave restart, stray stop.
	assign al_ev = en & ((ms_rise & bb_ff) | (rsta_req & ~is_ms) |
	               (stop_det & is_ms & (mstate_ff != i2sp_pkg::I2SP_M_STOP1) &
	                (mstate_ff != i2sp_pkg::I2SP_M_STOP2)) |
	               (scl_rise & xfer_ff & is_ms & ~data_low_ff & ~sda_s &
	                (tx_byte_ff ? (bit_ff < `I2SP_BIT_ACK) : (bit_ff == `I2SP_BIT_ACK))));
	assign al_lose = al_ev & is_ms;

	// A data access launches a byte only when the direction select matches it.
	assign ready_w = ~xfer_ff & ((is_ms & (mstate_ff == i2sp_pkg::I2SP_M_HOLD)) | (~is_ms & slv_on_ff));
	assign tx_go   = en & data_wr & ctrl_ff[`I2SP_CTL_TX] & ready_w;
	assign rx_go   = en & data_rd & ~ctrl_ff[`I2SP_CTL_TX] & ready_w;
	assign go      = tx_go | rx_go;

	// The byte ends on the falling edge of its ninth clock.
	assign done_w   = en & ~al_lose & xfer_ff & scl_fall & (bit_ff == `I2SP_BIT_DONE);
	assign tcf_set  = done_w & (~addr_ph_ff | match_ff);
	assign addressed_as_slave_flag_set = done_w & addr_ph_ff & match_ff;
	assign addr_in  = sh_ff[6:0];                 // Seven address bits are in when the direction bit arrives.

	assign status_w = {tcf_ff, addressed_as_slave_flag_ff, bb_ff, al_ff, 1'b0, srw_ff, iif_ff, received_ack_flag_ff};
	assign irq      = iif_ff & ctrl_ff[`I2SP_CTL_IE];
	assign scl_out  = 1'b0;
	assign sda_out  = 1'b0;
	assign scl_oe   = scl_low_ff | slv_hold_ff;
	assign sda_oe   = data_low_ff | cond_low_ff;
	assign t_zero   = (timer_ff == 8'h00);

	// Previous line levels for edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	// Control registers; losing arbitration drops master select without a stop.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = pwdata[7:0] & `I2SP_CTL_WMASK;
		end
		if (al_lose | (ms_rise & bb_ff)) begin
			nxt_ctrl[`I2SP_CTL_MS] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `I2SP_CTL_RST;
			general_call_accept_ff <= 1'b0;
			own_ff  <= `I2SP_OWN_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr & (paddr == `I2SP_OFS_CONTROL2)) begin
				general_call_accept_ff <= pwdata[`I2SP_CT2_GENERAL_CALL_ACCEPT];
			end
			if (wr & (paddr == `I2SP_OFS_OWN_ADDR)) begin
				own_ff <= pwdata[7:1];
			end
		end
	end

	// Read data is captured in the setup cycle; the data port returns the last received byte.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (psel & ~penable) begin
			pslverr_ff <= ~mapped;
			unique case (paddr)
				`I2SP_OFS_OWN_ADDR: prdata_ff <= {24'h00_0000, own_ff, 1'b0};
				`I2SP_OFS_CONTROL:  prdata_ff <= {24'h00_0000, ctrl_ff};
				`I2SP_OFS_STATUS:   prdata_ff <= {24'h00_0000, status_w};
				`I2SP_OFS_DATA:     prdata_ff <= {24'h00_0000, rx_data_ff};
				`I2SP_OFS_CONTROL2: prdata_ff <= {24'h00_0000, general_call_accept_ff, 7'h00};
				default:            prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Byte engine shared by master and slave; it follows the observed clock edges.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_ff     <= 1'b0;
			bit_ff      <= 4'h0;
			sh_ff       <= 8'h00;
			tx_byte_ff  <= 1'b0;
			addr_ph_ff  <= 1'b0;
			match_ff    <= 1'b0;
			data_low_ff <= 1'b0;
			rx_data_ff  <= 8'h00;
			received_ack_flag_ff     <= 1'b1;
			slv_on_ff   <= 1'b0;
			slv_hold_ff <= 1'b0;
			srw_ff      <= 1'b0;
		end else if (!en || al_lose || stop_det) begin
			xfer_ff     <= 1'b0;
			bit_ff      <= 4'h0;
			addr_ph_ff  <= 1'b0;
			data_low_ff <= 1'b0;
			slv_on_ff   <= 1'b0;
			slv_hold_ff <= 1'b0;
		end else if (start_det && !is_ms) begin
			xfer_ff     <= 1'b1;
			bit_ff      <= 4'h0;
			tx_byte_ff  <= 1'b0;
			addr_ph_ff  <= 1'b1;
			match_ff    <= 1'b0;
			data_low_ff <= 1'b0;
			slv_on_ff   <= 1'b0;
			slv_hold_ff <= 1'b0;
		end else if (go) begin
			xfer_ff     <= 1'b1;
			bit_ff      <= 4'h0;
			tx_byte_ff  <= tx_go;
			slv_hold_ff <= 1'b0;                 // Releasing the stretched clock lets the master go on.
			if (tx_go) begin
				sh_ff       <= pwdata[7:0];
				data_low_ff <= ~pwdata[7];
			end
		end else if (xfer_ff && scl_rise) begin
			if (bit_ff < `I2SP_BIT_ACK) begin
				sh_ff  <= {sh_ff[6:0], sda_s};
				bit_ff <= bit_ff + 4'h1;
				if (addr_ph_ff && bit_ff == `I2SP_BIT_LAST) begin
					match_ff <= (addr_in == own_ff) | (general_call_accept_ff & (addr_in == `I2SP_GENERAL_CALL));
				end
			end else if (bit_ff == `I2SP_BIT_ACK) begin
				bit_ff <= `I2SP_BIT_DONE;
				if (tx_byte_ff) begin
					received_ack_flag_ff <= sda_s;
				end
			end
		end else if (xfer_ff && scl_fall) begin
			if (bit_ff == `I2SP_BIT_DONE) begin
				xfer_ff     <= 1'b0;
				bit_ff      <= 4'h0;
				data_low_ff <= 1'b0;
				addr_ph_ff  <= 1'b0;
				if (!tx_byte_ff && !addr_ph_ff) begin
					rx_data_ff <= sh_ff;
				end
				if (addr_ph_ff && match_ff) begin
					srw_ff    <= sh_ff[0];
					slv_on_ff <= 1'b1;
				end
				slv_hold_ff <= ~is_ms & (slv_on_ff | (addr_ph_ff & match_ff));
			end else if (bit_ff == `I2SP_BIT_ACK) begin
				// Address matches are always acknowledged; data follows the acknowledge select.
				data_low_ff <= ~tx_byte_ff & (addr_ph_ff ? match_ff : ~ctrl_ff[`I2SP_CTL_TXAK]);
			end else if (bit_ff != 4'h0) begin
				data_low_ff <= tx_byte_ff & ~sh_ff[7];
			end
		end
	end

	// Status flags; a hardware set wins over a software clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcf_ff  <= `I2SP_ST_TCF_RST;
			addressed_as_slave_flag_ff <= 1'b0;
			bb_ff   <= 1'b0;
			al_ff   <= 1'b0;
			iif_ff  <= 1'b0;
		end else begin
			if (tcf_set) begin
				tcf_ff <= 1'b1;
			end else if (go || (start_det && !is_ms)) begin
				tcf_ff <= 1'b0;
			end
			if (addressed_as_slave_flag_set) begin
				addressed_as_slave_flag_ff <= 1'b1;
			end else if (wr_ctrl) begin
				addressed_as_slave_flag_ff <= 1'b0;
			end
			if (start_det) begin
				bb_ff <= 1'b1;
			end else if (stop_det) begin
				bb_ff <= 1'b0;
			end
			if (al_ev) begin
				al_ff <= 1'b1;
			end else if (wr_stat && pwdata[`I2SP_ST_AL]) begin
				al_ff <= 1'b0;
			end
			if (al_ev || tcf_set || addressed_as_slave_flag_set) begin
				iif_ff <= 1'b1;
			end else if (wr_stat && pwdata[`I2SP_ST_IIF]) begin
				iif_ff <= 1'b0;
			end
		end
	end

	// Master sequencer: start, clocking of each byte, repeated start and stop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mstate_ff   <= i2sp_pkg::I2SP_M_IDLE;
			timer_ff    <= 8'h00;
			scl_low_ff  <= 1'b0;
			cond_low_ff <= 1'b0;
		end else if (!en || al_lose) begin
			mstate_ff   <= i2sp_pkg::I2SP_M_IDLE;
			scl_low_ff  <= 1'b0;
			cond_low_ff <= 1'b0;
		end else begin
			if (!t_zero) begin
				timer_ff <= timer_ff - 8'h01;
			end
			unique case (mstate_ff)
				i2sp_pkg::I2SP_M_IDLE: begin
					if (ms_rise && !bb_ff) begin
						cond_low_ff <= 1'b1;
						timer_ff    <= 8'(HALF_CYC);
						mstate_ff   <= i2sp_pkg::I2SP_M_START;
					end
				end
				i2sp_pkg::I2SP_M_START: begin
					// SDA stays low until the first bit; releasing it as SCL falls could pass for a stop.
					if (t_zero) begin
						scl_low_ff  <= 1'b1;
						mstate_ff   <= i2sp_pkg::I2SP_M_HOLD;
					end
				end
				i2sp_pkg::I2SP_M_HOLD: begin
					if (go) begin
						cond_low_ff <= 1'b0;
						timer_ff  <= 8'(HALF_CYC);
						mstate_ff <= i2sp_pkg::I2SP_M_CLK;
					end else if (rsta_req) begin
						scl_low_ff <= 1'b0;
						timer_ff   <= 8'(HALF_CYC);
						mstate_ff  <= i2sp_pkg::I2SP_M_RS;
					end else if (ms_fall) begin
						cond_low_ff <= 1'b1;
						timer_ff    <= 8'(HALF_CYC);
						mstate_ff   <= i2sp_pkg::I2SP_M_STOP1;
					end
				end
				i2sp_pkg::I2SP_M_CLK: begin
					if (done_w) begin
						scl_low_ff <= 1'b1;
						mstate_ff  <= i2sp_pkg::I2SP_M_HOLD;
					end else if (t_zero) begin
						scl_low_ff <= ~scl_low_ff;
						timer_ff   <= 8'(HALF_CYC);
					end
				end
				i2sp_pkg::I2SP_M_RS: begin
					if (t_zero) begin
						cond_low_ff <= 1'b1;
						timer_ff    <= 8'(HALF_CYC);
						mstate_ff   <= i2sp_pkg::I2SP_M_START;
					end
				end
				i2sp_pkg::I2SP_M_STOP1: begin
					if (t_zero) begin
						scl_low_ff <= 1'b0;
						timer_ff   <= 8'(HALF_CYC);
						mstate_ff  <= i2sp_pkg::I2SP_M_STOP2;
					end
				end
				i2sp_pkg::I2SP_M_STOP2: begin
					if (t_zero) begin
						cond_low_ff <= 1'b0;         // SDA rising while SCL is high is the stop.
						mstate_ff   <= i2sp_pkg::I2SP_M_IDLE;
					end
				end
				default: begin
					mstate_ff <= i2sp_pkg::I2SP_M_IDLE;
				end
			endcase
		end
	end

	// Checks on the flags and the data port.
	a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && paddr == `I2SP_OFS_STATUS) |=> prdata_ff[3] == 1'b0)
		else $error("Reserved status bit read as one.");
	a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(iif_ff) && ctrl_ff[`I2SP_CTL_IE]) |-> irq)
		else $error("Interrupt request missing with flag and enable set.");
	a_al_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(al_ff && wr_stat && !pwdata[`I2SP_ST_AL]) |=> al_ff)
		else $error("Arbitration lost flag cleared by a zero write.");
	a_iif_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(iif_ff && !(wr_stat && pwdata[`I2SP_ST_IIF])) |=> iif_ff)
		else $error("Interrupt flag cleared without a one write.");
	a_done_flags: assert property (@(posedge pclk) disable iff (!presetn)
		tcf_set |=> (tcf_ff && iif_ff))
		else $error("Byte end did not set complete and interrupt flags.");
	a_ctrl_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ctrl && !addressed_as_slave_flag_set) |=> !addressed_as_slave_flag_ff)
		else $error("Control write left the addressed flag set.");
	a_bus_busy: assert property (@(posedge pclk) disable iff (!presetn)
		(start_det |=> bb_ff) and (stop_det && !start_det |=> !bb_ff))
		else $error("Bus busy flag does not follow start and stop.");
	a_tx_msb: assert property (@(posedge pclk) disable iff (!presetn)
		tx_go |=> (sda_oe == ~$past(pwdata[7])))
		else $error("Transmit did not put the most significant bit on the line.");
	a_dir_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(data_rd && ctrl_ff[`I2SP_CTL_TX] && !data_wr) |=> !$rose(xfer_ff) || $past(start_det))
		else $error("Data read launched a byte in transmit mode.");

endmodule

/* File: core/i2sp_sync.sv */
// Two-flip-flop synchronisers for the serial clock and data lines.
// Assumes pclk and an asynchronous active-low reset; lines idle high.
module i2sp_sync (
	input  wire logic     pclk,
	input  wire logic     presetn,
	i2sp_line_if.sync_mp  line
);

	logic [1:0] meta_ff;
	logic [1:0] sync_ff;

	// The first stage is read only by the second; both reset to the idle high level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= 2'h3;
			sync_ff <= 2'h3;
		end else begin
			meta_ff <= {line.scl_raw, line.sda_raw};
			sync_ff <= meta_ff;
		end
	end

	assign line.scl_sync = sync_ff[1];
	assign line.sda_sync = sync_ff[0];

endmodule

/* File: sim/i2c_status_and_data_port_bench.sv */
// Self-checking bench: drives the port over APB and talks to one slave model on the bus.
// Assumes the port's pready answer and a 10 MHz pclk.
`include "i2sp_defines.svh"
module i2c_status_and_data_port_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, scl_out, scl_oe, sda_out, sda_oe, m_oe, err;
	logic [7:0]  got;
	int          bad_count = 0;
	int          n_checks = 0;
	logic        b_scl = 1'b0;                  // Pull-downs of the far master that calls the port.
	logic        b_sda = 1'b0;
	wire         scl = ~(scl_oe | b_scl);
	wire         sda = ~(sda_oe | m_oe | b_sda);

	always #50 pclk = ~pclk;

	i2sp_port #(.HALF_CYC(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	i2sp_slave_model #(.ADDR(7'h2A)) i_slave (.scl(scl), .sda(sda), .sda_oe(m_oe), .last_byte(got));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Polls status until the byte completes; a bounded count keeps a stuck flag from hanging.
	task automatic wait_tcf(output logic [31:0] r);
		int n;
		n = 0;
		do begin
			apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
			n++;
		end while (r[`I2SP_ST_TCF] !== 1'b1 && n < 200);
	endtask

	// Far master clocks one bit: a one releases SDA, and the line is sampled while SCL is high.
	task automatic bus_bit(input logic b, output logic s);
		b_sda <= ~b;
		repeat (8) @(posedge pclk);
		b_scl <= 1'b0;
		repeat (8) @(posedge pclk);
		s = sda;
		b_scl <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask

	// Eight data bits, most significant first, then the acknowledge bit.
	task automatic bus_byte(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			bus_bit(d[i], q[i]);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence: reset values, a bad address, two framed writes and a refused read.
	initial begin
		logic [31:0] r;
		logic [8:0]  q;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
		check("status reset", r, 32'h81);
		apb(1'b0, 8'h14, 32'h0, r);
		check("unmapped error", {31'h0, err}, 32'h1);
		apb(1'b1, `I2SP_OFS_CONTROL, 32'hC0, r);
		for (int k = 0; k < 2; k++) begin
			apb(1'b1, `I2SP_OFS_CONTROL, 32'hF0, r);
			repeat (20) @(posedge pclk);
			apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
			check("busy after start", r, (k == 0) ? 32'hA1 : 32'hA0);
			apb(1'b1, `I2SP_OFS_DATA, (k == 0) ? 32'h54 : 32'h2A, r);
			wait_tcf(r);
			check("address status", r, (k == 0) ? 32'hA2 : 32'hA3);
			check("irq level", {31'h0, irq}, 32'h1);
			apb(1'b1, `I2SP_OFS_STATUS, 32'h0, r);
			apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
			check("zero write keeps flag", r[1], 32'h1);
			apb(1'b1, `I2SP_OFS_STATUS, 32'h02, r);
			// The clear lands at the edge that ends the write, so the level is looked at half a cycle later.
			@(negedge pclk);
			check("irq after clear", {31'h0, irq}, 32'h0);
			if (k == 0) begin
				apb(1'b0, `I2SP_OFS_DATA, 32'h0, r);
				repeat (100) @(posedge pclk);
				apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
				check("read in transmit idle", r, 32'hA0);
				apb(1'b1, `I2SP_OFS_DATA, 32'hC3, r);
				wait_tcf(r);
				check("data byte status", r, 32'hA2);
				check("byte on wire", got, 32'hC3);
				apb(1'b1, `I2SP_OFS_STATUS, 32'h02, r);
			end
			apb(1'b1, `I2SP_OFS_CONTROL, 32'hD0, r);
			repeat (40) @(posedge pclk);
			apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
			check("idle after stop", r, (k == 0) ? 32'h80 : 32'h81);
		end
		// Slave receive: a far master calls the own address, writes one byte and stops.
		apb(1'b1, `I2SP_OFS_OWN_ADDR, 32'h66, r);
		apb(1'b1, `I2SP_OFS_CONTROL, 32'hC0, r);
		b_sda <= 1'b1;
		repeat (8) @(posedge pclk);
		b_scl <= 1'b1;
		repeat (8) @(posedge pclk);
		bus_byte({8'h66, 1'b1}, q);
		check("slave address ack", {31'h0, q[0]}, 32'h0);
		apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
		check("addressed status", r, 32'hE3);
		apb(1'b1, `I2SP_OFS_CONTROL, 32'hC0, r);
		apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
		check("control write clears addressed", r, 32'hA3);
		apb(1'b0, `I2SP_OFS_DATA, 32'h0, r);
		apb(1'b1, `I2SP_OFS_STATUS, 32'h02, r);
		bus_byte({8'h5C, 1'b1}, q);
		check("slave data ack", {31'h0, q[0]}, 32'h0);
		wait_tcf(r);
		check("received status", r, 32'hA3);
		apb(1'b0, `I2SP_OFS_DATA, 32'h0, r);
		check("received byte", r, 32'h5C);
		b_sda <= 1'b1;
		repeat (8) @(posedge pclk);
		b_scl <= 1'b0;
		repeat (8) @(posedge pclk);
		b_sda <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, `I2SP_OFS_STATUS, 32'h0, r);
		check("idle after slave stop", r, 32'h03);
		stop_test();
	end

	// Watchdog: the sequence needs a little over a thousand cycles.
	initial begin
		#1000000;
		bad_count++;
		stop_test();
	end
endmodule

/* File: sim/i2sp_slave_model.sv */
// Behavioural slave on the two-wire bus: takes the address byte and the data bytes written to it.
// Assumes wired-AND line levels with pull-ups; it pulls SDA low through sda_oe only.
module i2sp_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sda_oe,
	output logic [7:0]      last_byte
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic       first;
	logic       sel;

	initial begin
		sda_oe = 1'b0;
		cnt = 4'h0;
		sh = 8'h00;
		first = 1'b0;
		sel = 1'b0;
		last_byte = 8'h00;
	end

	// A start or a stop restarts the byte count, so a stray clock shifts the frame only until the next start or stop.
	always @(sda) begin
		if (scl) begin
			cnt = 4'h0;
			first = !sda;
			sel = 1'b0;
		end
	end

	// Data are sampled while SCL is high, most significant bit first.
	always @(posedge scl) begin
		if (cnt < 4'h8)
			sh = {sh[6:0], sda};
		cnt = cnt + 4'h1;
	end

	// The acknowledge is driven from the eighth falling edge, through the ninth clock, and released at the ninth falling edge.
	always @(negedge scl) begin
		if (cnt == 4'h8) begin
			if (first)
				sel = (sh[7:1] == ADDR);
			else if (sel)
				last_byte = sh;
			first = 1'b0;
			sda_oe = sel;
		end else if (cnt == 4'h9) begin
			sda_oe = 1'b0;
			cnt = 4'h0;
		end
	end
endmodule
